// ### rtl/dirc_defs.vh
`ifndef DIRC_DEFS_VH
`define DIRC_DEFS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define DIRC_ADDR_OWN_BUS_ADDRESS 8'h00
`define DIRC_ADDR_SOFT_RESET 8'h01
`define DIRC_ADDR_GENERAL_CFG 8'h02
`define DIRC_ADDR_CHIP_STATUS 8'h04

// ****************************************************************
// Field positions
// ****************************************************************
`define DIRC_BIT_ADDR_OVERRIDE 0
`define DIRC_BIT_ROM_RELOAD 2
`define DIRC_BIT_FULL_RESET 1
`define DIRC_BIT_LOGIC_RESET 0
`define DIRC_BIT_INPUT_OVERRIDE 7
`define DIRC_BIT_INPUT_SEL 6
`define DIRC_BIT_OUTPUT_OVERRIDE 5
`define DIRC_BIT_CFG_RSVD4 4
`define DIRC_BIT_OUTPUT_ENABLE 3
`define DIRC_BIT_SLEEP_SEL 2
`define DIRC_BIT_INIT_DONE 6

// ****************************************************************
// Reset values
// ****************************************************************
`define DIRC_RST_ADDRESS_FIELD 7'h3d
`define DIRC_RST_ADDR_OVERRIDE 1'b0
`define DIRC_RST_RESET_RSVD 5'h00
`define DIRC_RST_GEN_CFG 6'h07

// ****************************************************************
// Timing
// ****************************************************************
`define DIRC_CLK_PERIOD_NS 4
`define DIRC_ROM_LOAD_NS 2000
`define DIRC_ROM_LOAD_CYCLES (`DIRC_ROM_LOAD_NS / `DIRC_CLK_PERIOD_NS)

`endif

// ### rtl/dirc_regs.v
`timescale 1ns/1ps
`include "dirc_defs.vh"

module dirc_regs #(
	parameter [6:0] STRAP_ADDR_LOW = `DIRC_RST_ADDRESS_FIELD,
	parameter [6:0] STRAP_ADDR_HIGH = 7'h3c,
	parameter ROM_LOAD_CYCLES = `DIRC_ROM_LOAD_CYCLES
) (
	input wire CLK,
	input wire RST,
	input wire [7:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	output reg [7:0] REG_RDATA,
	output reg REG_RVALID,
	input wire ADDRESS_STRAP_PIN,
	input wire INPUT_SEL_PIN,
	input wire OUTPUTS_ON_PIN,
	input wire UNLOCKED_STATE_PIN,
	input wire LINK_LOCKED,
	output reg [6:0] OWN_ADDRESS,
	output reg LOGIC_RESET,
	output reg ROM_LOADING,
	output reg INIT_DONE,
	output reg ACTIVE_INPUT_PORT,
	output reg OUTPUTS_ENABLE,
	output reg OUTPUTS_HIZ,
	output reg OUTPUTS_IDLE_LOW
);
	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	wire [3:0] pins_sync;
	wire strap_pin = pins_sync[0];
	wire sel_pin = pins_sync[1];
	wire oen_pin = pins_sync[2];
	wire oss_pin = pins_sync[3];

	dirc_sync #(
		.WIDTH(4)
	) u_sync (
		.CLK(CLK),
		.D({UNLOCKED_STATE_PIN, OUTPUTS_ON_PIN, INPUT_SEL_PIN,
			ADDRESS_STRAP_PIN}),
		.Q(pins_sync)
	);

	// ****************************************************************
	// Register state
	// ****************************************************************
	reg full_reset;
	reg strap_taken;
	reg [6:0] strap_addr;
	reg [6:0] addr_field;
	reg addr_override;
	reg [4:0] reset_rsvd;
	reg input_override;
	reg input_sel;
	reg output_override;
	reg cfg_rsvd4;
	reg output_enable;
	reg sleep_sel;
	reg [31:0] load_count;
	reg [31:0] next_load_count;
	reg next_rom_loading;
	reg next_init_done;
	reg [6:0] next_own_address;
	reg next_active_input;
	reg next_outputs_enable;
	reg next_outputs_hiz;
	reg next_outputs_idle_low;
	reg [7:0] next_rdata;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Bus strobe aimed at one register offset
	function reg_hit;
		input strobe;
		input [7:0] addr;
		input [7:0] target;
		begin
			reg_hit = strobe && (addr == target);
		end
	endfunction

	// Register copy wins over the synchronised pin when overridden
	function pick;
		input override;
		input reg_val;
		input pin_val;
		begin
			pick = override ? reg_val : pin_val;
		end
	endfunction

	// Register state is cleared by the pin reset and the full soft reset
	wire reg_rst = RST | full_reset;
	wire wr_addr = reg_hit(REG_WR, REG_ADDR,
		`DIRC_ADDR_OWN_BUS_ADDRESS);
	wire wr_reset = reg_hit(REG_WR, REG_ADDR,
		`DIRC_ADDR_SOFT_RESET);
	wire wr_cfg = reg_hit(REG_WR, REG_ADDR,
		`DIRC_ADDR_GENERAL_CFG);

	wire eff_input = pick(input_override, input_sel, sel_pin);
	wire eff_oe = pick(output_override, output_enable, oen_pin);
	wire eff_oss = pick(output_override, sleep_sel, oss_pin);
	wire [6:0] eff_addr = addr_override ? addr_field : strap_addr;

	// ****************************************************************
	// Soft reset pulses
	// ****************************************************************
	// One-cycle pulses; the trigger bits never hold a 1, so reads give 0
	always @(posedge CLK) begin
		if (RST) begin
			full_reset <= 1'b0;
			LOGIC_RESET <= 1'b0;
		end else begin
			full_reset <= wr_reset && REG_WDATA[`DIRC_BIT_FULL_RESET];
			// Logic reset also follows a full reset
			LOGIC_RESET <= wr_reset &&
				(REG_WDATA[`DIRC_BIT_LOGIC_RESET] ||
				REG_WDATA[`DIRC_BIT_FULL_RESET]);
		end
	end

	// ****************************************************************
	// Strap capture and own address
	// ****************************************************************
	// Strap is caught once, on the first cycle after reset release
	always @(posedge CLK) begin
		if (reg_rst) begin
			strap_taken <= 1'b0;
			strap_addr <= STRAP_ADDR_LOW;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1;
			strap_addr <= strap_pin ? STRAP_ADDR_HIGH : STRAP_ADDR_LOW;
		end
	end

	always @(posedge CLK) begin
		if (reg_rst) begin
			addr_field <= `DIRC_RST_ADDRESS_FIELD;
			addr_override <= `DIRC_RST_ADDR_OVERRIDE;
			reset_rsvd <= `DIRC_RST_RESET_RSVD;
		end else begin
			if (wr_addr) begin
				addr_override <= REG_WDATA[`DIRC_BIT_ADDR_OVERRIDE];
				// Field only takes a write when the same write enables override
				if (REG_WDATA[`DIRC_BIT_ADDR_OVERRIDE])
					addr_field <= REG_WDATA[7:1];
			end
			if (wr_reset)
				reset_rsvd <= REG_WDATA[7:3];
		end
	end

	// ****************************************************************
	// General configuration
	// ****************************************************************
	always @(posedge CLK) begin
		if (reg_rst) begin
			{input_override, input_sel, output_override, cfg_rsvd4,
				output_enable, sleep_sel} <= `DIRC_RST_GEN_CFG;
		end else if (wr_cfg) begin
			input_override <= REG_WDATA[`DIRC_BIT_INPUT_OVERRIDE];
			input_sel <= REG_WDATA[`DIRC_BIT_INPUT_SEL];
			output_override <= REG_WDATA[`DIRC_BIT_OUTPUT_OVERRIDE];
			cfg_rsvd4 <= REG_WDATA[`DIRC_BIT_CFG_RSVD4];
			output_enable <= REG_WDATA[`DIRC_BIT_OUTPUT_ENABLE];
			sleep_sel <= REG_WDATA[`DIRC_BIT_SLEEP_SEL];
		end
	end

	// ****************************************************************
	// Configuration ROM load sequencer
	// ****************************************************************
	// Load runs after a pin or full reset and on a reload request; a reload
	// written mid-load restarts the count rather than queueing
	always @(posedge CLK) begin
		if (reg_rst) begin
			load_count <= 32'h00000000;
			ROM_LOADING <= 1'b1;
			INIT_DONE <= 1'b0;
		end else begin
			load_count <= next_load_count;
			ROM_LOADING <= next_rom_loading;
			INIT_DONE <= next_init_done;
		end
	end

	always @* begin
		next_load_count = load_count;
		next_rom_loading = ROM_LOADING;
		next_init_done = INIT_DONE;
		if (wr_reset && REG_WDATA[`DIRC_BIT_ROM_RELOAD]) begin
			next_load_count = 32'h00000000;
			next_rom_loading = 1'b1;
			next_init_done = 1'b0;
		end else if (ROM_LOADING) begin
			if (load_count >= ROM_LOAD_CYCLES - 1) begin
				next_rom_loading = 1'b0;
				next_init_done = 1'b1;
			end else begin
				next_load_count = load_count + 32'h00000001;
			end
		end
	end

	// ****************************************************************
	// Output control
	// ****************************************************************
	always @(posedge CLK) begin
		if (reg_rst) begin
			OWN_ADDRESS <= `DIRC_RST_ADDRESS_FIELD;
			ACTIVE_INPUT_PORT <= 1'b0;
			OUTPUTS_ENABLE <= 1'b0;
			OUTPUTS_HIZ <= 1'b0;
			OUTPUTS_IDLE_LOW <= 1'b0;
		end else begin
			OWN_ADDRESS <= next_own_address;
			ACTIVE_INPUT_PORT <= next_active_input;
			OUTPUTS_ENABLE <= next_outputs_enable;
			OUTPUTS_HIZ <= next_outputs_hiz;
			OUTPUTS_IDLE_LOW <= next_outputs_idle_low;
		end
	end

	// ****************************************************************
	// Read port
	// ****************************************************************
	always @(posedge CLK) begin
		if (RST) begin
			REG_RDATA <= 8'h00;
			REG_RVALID <= 1'b0;
		end else begin
			REG_RVALID <= REG_RD;
			REG_RDATA <= next_rdata;
		end
	end

	// ****************************************************************
	// Read data select
	// ****************************************************************
	// Idle data is zero so a stale word never looks like an answer
	always @* begin
		next_rdata = 8'h00;
		if (!REG_RD)
			next_rdata = 8'h00;
		else if (reg_hit(REG_RD, REG_ADDR, `DIRC_ADDR_OWN_BUS_ADDRESS))
			next_rdata = {eff_addr, addr_override};
		else if (reg_hit(REG_RD, REG_ADDR, `DIRC_ADDR_SOFT_RESET))
			next_rdata = {reset_rsvd, 3'h0};
		else if (reg_hit(REG_RD, REG_ADDR, `DIRC_ADDR_GENERAL_CFG))
			next_rdata = {input_override, eff_input, output_override,
				cfg_rsvd4, eff_oe, eff_oss, 2'h0};
		else if (reg_hit(REG_RD, REG_ADDR, `DIRC_ADDR_CHIP_STATUS))
			next_rdata = {1'b0, INIT_DONE, 6'h00};
		else
			next_rdata = 8'h00;
	end

	// ****************************************************************
	// Output next values
	// ****************************************************************
	always @* begin
		next_own_address = eff_addr;
		next_active_input = eff_input;
		next_outputs_enable = eff_oe;
		next_outputs_hiz = eff_oss & ~eff_oe;
		// Idle drive only matters without lock; high impedance wins
		next_outputs_idle_low = ~LINK_LOCKED & ~eff_oss;
	end
endmodule

// ### rtl/dirc_sync.v
`timescale 1ns/1ps

// ****************************************************************
// Two-flop synchroniser for pin levels
// ****************************************************************
module dirc_sync #(
	parameter WIDTH = 4
) (
	input wire CLK,
	input wire [WIDTH-1:0] D,
	output reg [WIDTH-1:0] Q
);
	// First stage is read by the second stage only
	reg [WIDTH-1:0] meta;

	always @(posedge CLK) begin
		meta <= D;
		Q <= meta;
	end
endmodule

// ### tb/dirc_host.sv
`timescale 1ns/1ps
// ***
// Register host
// ***
module dirc_host (
	input wire CLK,
	input wire [7:0] RDATA,
	input wire RVALID,
	output reg [7:0] ADDR = 8'h00,
	output reg [7:0] WDATA = 8'h00,
	output reg WR = 1'b0,
	output reg RD = 1'b0
);
	// Idle data flips after a write and idle address after a read so stale values are never trusted
	task wr(input [7:0] a, input [7:0] d);
		@(negedge CLK);
		ADDR = a;
		WDATA = d;
		WR = 1'b1;
		@(negedge CLK);
		WR = 1'b0;
		WDATA = ~d;
	endtask
	task rd(input [7:0] a, output [7:0] d);
		@(negedge CLK);
		ADDR = a;
		RD = 1'b1;
		@(negedge CLK);
		RD = 1'b0;
		ADDR = ~a;
		d = RVALID ? RDATA : 8'hxx;
	endtask
endmodule

// ### tb/dirc_regs_monitor.sv
`timescale 1ns/1ps
// ***
// Register bank checker
// ***
module dirc_regs_monitor #(
	parameter ROM_LOAD_CYCLES = 4
) (
	input wire CLK,
	input wire RST,
	input wire [7:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	input wire [7:0] REG_RDATA,
	input wire LINK_LOCKED,
	input wire [6:0] OWN_ADDRESS,
	input wire LOGIC_RESET,
	input wire ROM_LOADING,
	input wire INIT_DONE,
	input wire ACTIVE_INPUT_PORT,
	input wire OUTPUTS_ENABLE,
	input wire OUTPUTS_HIZ,
	input wire OUTPUTS_IDLE_LOW
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	wire w0 = REG_WR && REG_ADDR == 8'h00;
	wire w1 = REG_WR && REG_ADDR == 8'h01;
	wire w2 = REG_WR && REG_ADDR == 8'h02;
	property p_ad; w0 && REG_WDATA[0] |=> ##1
		OWN_ADDRESS == $past(REG_WDATA[7:1], 2); endproperty
	a_ad: assert property (p_ad) else $error("address");
	property p_ld; w1 && REG_WDATA[2] |=> ROM_LOADING && !INIT_DONE;
	endproperty
	a_ld: assert property (p_ld) else $error("reload");
	property p_fr; w1 && REG_WDATA[1] |-> ##[1:4] ROM_LOADING; endproperty
	a_fr: assert property (p_fr) else $error("full reset");
	property p_lr; w1 && REG_WDATA[0] |-> ##[1:2] LOGIC_RESET ##1
		!LOGIC_RESET; endproperty
	a_lr: assert property (p_lr) else $error("logic reset");
	property p_ip; w2 && REG_WDATA[7] |=> ##1
		ACTIVE_INPUT_PORT == $past(REG_WDATA[6], 2); endproperty
	a_ip: assert property (p_ip) else $error("input port");
	property p_oe; w2 && REG_WDATA[5] |=> ##1
		OUTPUTS_ENABLE == $past(REG_WDATA[3], 2); endproperty
	a_oe: assert property (p_oe) else $error("enable");
	property p_hz; OUTPUTS_HIZ |-> !OUTPUTS_ENABLE; endproperty
	a_hz: assert property (p_hz) else $error("hiz");
	property p_il; OUTPUTS_IDLE_LOW |-> !$past(LINK_LOCKED); endproperty
	a_il: assert property (p_il) else $error("idle low");
	property p_rc; REG_RD && REG_ADDR == 8'h01 |=> REG_RDATA[2:0] == 3'h0;
	endproperty
	a_rc: assert property (p_rc) else $error("self clear");
	c_rl: cover property (w1 && REG_WDATA[2]);
	c_hz: cover property (OUTPUTS_HIZ);
	c_il: cover property (OUTPUTS_IDLE_LOW);
endmodule
bind dirc_regs dirc_regs_monitor #(.ROM_LOAD_CYCLES(ROM_LOAD_CYCLES)) u_mon (.*);

// ### tb/test_deser_id_reset_config_regs.sv
`timescale 1ns/1ps
module test_deser_id_reset_config_regs;
	reg clk = 1'b0, rst = 1'b1, strap = 1'b0, sel = 1'b1;
	reg oe = 1'b0, oss = 1'b1, lock = 1'b0;
	wire [7:0] addr, wdata, rdata;
	wire wr, rd, rv, lrst, ldg, done, port, outputs_on_pin, hiz, idle;
	wire [6:0] own;
	reg [7:0] d;
	reg [24:0] rows [0:8];
	integer i, errors = 0, num_checks = 0;
	always #2 clk = ~clk;
	dirc_regs #(.ROM_LOAD_CYCLES(4)) dut (.CLK(clk), .RST(rst),
		.REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
		.REG_RDATA(rdata), .REG_RVALID(rv), .ADDRESS_STRAP_PIN(strap),
		.INPUT_SEL_PIN(sel), .OUTPUTS_ON_PIN(oe), .UNLOCKED_STATE_PIN(oss),
		.LINK_LOCKED(lock), .OWN_ADDRESS(own), .LOGIC_RESET(lrst),
		.ROM_LOADING(ldg), .INIT_DONE(done), .ACTIVE_INPUT_PORT(port),
		.OUTPUTS_ENABLE(outputs_on_pin), .OUTPUTS_HIZ(hiz), .OUTPUTS_IDLE_LOW(idle));
	dirc_host h (.CLK(clk), .RDATA(rdata), .RVALID(rv), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd));
	task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
		num_checks = num_checks + 1;
		if (g !== e) begin
			errors = errors + 1;
			$display("unexpected %0s exp %h got %h", nm, e, g);
		end
	endtask
	task test_done;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Hangs end here, generous against the fewer than a hundred cycles needed
	initial begin
		#20000;
		errors = errors + 1;
		test_done;
	end
	initial begin
		rows[0] = {1'b0, 8'h00, 8'h00, 8'h7a};
		rows[1] = {1'b1, 8'h00, 8'h20, 8'h7a};
		rows[2] = {1'b1, 8'h00, 8'h21, 8'h21};
		rows[3] = {1'b0, 8'h02, 8'h00, 8'h54};
		rows[4] = {1'b1, 8'h02, 8'ha3, 8'ha0};
		rows[5] = {1'b1, 8'h01, 8'hf8, 8'hf8};
		rows[6] = {1'b1, 8'h03, 8'hff, 8'h00};
		rows[7] = {1'b1, 8'h01, 8'hf9, 8'hf8};
		rows[8] = {1'b0, 8'h00, 8'h00, 8'h21};
		repeat (6) @(negedge clk);
		rst = 1'b0;
		for (i = 0; i < 9; i = i + 1) begin
			if (rows[i][24])
				h.wr(rows[i][23:16], rows[i][15:8]);
			h.rd(rows[i][23:16], d);
			chk("row", rows[i][7:0], d);
		end
		chk("outs", 8'h01, {port, outputs_on_pin, hiz, idle});
		lock = 1'b1;
		h.wr(8'h01, 8'h04);
		@(negedge clk);
		chk("load", 8'h02, {ldg, done});
		for (i = 0; i < 20 && done !== 1'b1; i = i + 1)
			@(negedge clk);
		h.rd(8'h04, d);
		chk("status", 8'h40, d);
		// Strap is only looked at when the bank restarts
		strap = 1'b1;
		repeat (4) @(negedge clk);
		h.wr(8'h01, 8'h02);
		repeat (4) @(negedge clk);
		h.rd(8'h00, d);
		chk("strap", 8'h78, d);
		h.rd(8'h02, d);
		chk("cfg", 8'h54, d);
		h.rd(8'h01, d);
		chk("rstreg", 8'h00, d);
		chk("pins", 8'h0a, {port, outputs_on_pin, hiz, idle});
		oss = 1'b0;
		lock = 1'b0;
		repeat (5) @(negedge clk);
		chk("idle", 8'h09, {port, outputs_on_pin, hiz, idle});
		test_done;
	end
endmodule
